//--- hw/ssld_core.sv
// shift-store led sink driver: pin sampler, edge queue, shift stages,
// latches, open-drain sinks and two cascade outputs
// assumes all pins are asynchronous to clk and the shift clock is much
// slower than clk; sink pins are resolved outside from the enables
// limits: pin pulses under about three clk periods may be lost, and an
// edge that meets a full queue is dropped, so hold queue_stall briefly
// the edge queue decouples sampling from shifting, so short stalls lose nothing
// trade-off: every pin is retimed, so sinks trail the pins by a few clk
`timescale 1ns/10ps
`include "ssld_regs.svh"
module ssld_core #(
  // stage count and edge queue depth
  parameter int STAGES = `SSLD_STAGES,
  parameter int DEPTH = `SSLD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // controller pins, all asynchronous
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic latch_transfer,
  input wire logic output_enable,
  // back-pressure on the edge queue
  input wire logic queue_stall,
  output logic edge_room,
  // sinks and cascades toward the leds and the next device
  output logic [STAGES-1:0] led_sink_outputs_o,
  output logic [STAGES-1:0] led_sink_outputs_oe,
  output logic cascade_out_rise,
  output logic cascade_out_fall
);
  // registered state and its next value
  ssld_pkg::ssld_state_t st_r;
  ssld_pkg::ssld_state_t st_nxt;
  // queue traffic
  ssld_pkg::ssld_event_t push_ev;
  ssld_pkg::ssld_event_t pop_ev;
  logic push_valid;
  logic pop_valid;
  logic pop_take;
  // decoded pin levels and edges
  logic rise_seen;
  logic fall_seen;
  logic stb_lvl;
  logic oe_lvl;

  // ------------------------------------------------------------
  // helpers for the next-state logic
  // ------------------------------------------------------------
  // one shift: new bit at stage 0, every other stage takes its lower
  function automatic logic [STAGES-1:0] shift_in(
    input logic [STAGES-1:0] cur,
    input logic bit_in
  );
    return {cur[STAGES-2:0], bit_in};
  endfunction : shift_in

  // open-drain enables: a stored one sinks, nothing while disabled
  function automatic logic [STAGES-1:0] sink_enables(
    input logic [STAGES-1:0] lat,
    input logic en
  );
    return en ? lat : {STAGES{1'b0}};
  endfunction : sink_enables

  // ------------------------------------------------------------
  // edge detection on the synchronised shift clock
  // ------------------------------------------------------------
  // data is synchronised alongside the clock, so it is the level
  // present when the edge is seen; it must be steady around the edge
  // a rise and a fall are never seen together: s2 differs from s3 one way
  assign rise_seen = st_r.pin_s2[`SSLD_PIN_CLK] & ~st_r.clk_s3;
  assign fall_seen = ~st_r.pin_s2[`SSLD_PIN_CLK] & st_r.clk_s3;
  assign push_valid = rise_seen | fall_seen;
  assign push_ev.is_rise = rise_seen;
  assign push_ev.data = st_r.pin_s2[`SSLD_PIN_DATA];
  assign stb_lvl = st_r.pin_s2[`SSLD_PIN_STB];
  assign oe_lvl = st_r.pin_s2[`SSLD_PIN_OE];
  assign pop_take = pop_valid & ~queue_stall;

  // edges queue up so a stalled core loses none until the queue fills
  // width two: edge direction and the data level seen with it
  ssld_fifo #(
    .WIDTH(2),
    .DEPTH(DEPTH)
  ) u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(edge_room),
    .in_data(push_ev),
    .out_valid(pop_valid),
    .out_ready(~queue_stall),
    .out_data(pop_ev)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // latency with an empty queue: a pin edge reaches s1, s2, the queue
  // and the stages on four clk edges; latches and sinks add one each.
  // the third clock flop only serves edge detection, never data.
  always_comb begin
    st_nxt = st_r;
    // two-flop sampler for all four pins, then the edge flop
    st_nxt.pin_s1 = {output_enable, latch_transfer, serial_in, shift_clock};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.clk_s3 = st_r.pin_s2[`SSLD_PIN_CLK];
    // a queued rising edge shifts and updates the rise cascade
    if (pop_take && pop_ev.is_rise) begin
      st_nxt.stages = shift_in(st_r.stages, pop_ev.data);
      st_nxt.casc_rise = st_r.stages[`SSLD_RISE_TAP];
    end
    // a queued falling edge only moves the fall cascade
    if (pop_take && !pop_ev.is_rise) begin
      st_nxt.casc_fall = st_r.stages[`SSLD_FALL_TAP];
    end
    // transparent while strobe high, one cycle behind the stages
    // strobe is a sampled level: a pulse under about two clk periods
    // may be missed entirely
    if (stb_lvl) begin
      st_nxt.latches = st_r.stages;
    end
    // a stored one sinks current; everything floats while disabled
    // registered so the pins never glitch when latches and enable
    // change in the same cycle
    st_nxt.sink_oe = sink_enables(st_r.latches, oe_lvl);
  end

  // reset only gives simulation a known start; logically the part has
  // no reset and holds its pattern while the shift clock is idle
  // ce low freezes the sampler too, so pin edges in that time are seen once ce returns; pulses are missed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs: sinks only ever pull low
  // ------------------------------------------------------------
  // tied low: only the enables move, so no sink can ever drive high
  assign led_sink_outputs_o = '0;
  assign led_sink_outputs_oe = st_r.sink_oe;
  assign cascade_out_rise = st_r.casc_rise;
  assign cascade_out_fall = st_r.casc_fall;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // all checks run on clk and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // shifting and edge intake
  shift_on_rise_a: assert property (ce && pop_take && pop_ev.is_rise |=>
    st_r.stages == {$past(st_r.stages[STAGES-2:0]), $past(pop_ev.data)})
    else $error("stages did not shift in the serial bit");
  no_shift_fall_a: assert property (ce && !(pop_take && pop_ev.is_rise) |=>
    $stable(st_r.stages))
    else $error("stages moved without a rising edge");
  edge_taken_a: assert property (ce && push_valid && edge_room |=> pop_valid)
    else $error("a sampled shift clock edge was lost");

  // latches
  latch_follow_a: assert property (ce && stb_lvl |=>
    st_r.latches == $past(st_r.stages))
    else $error("latches did not follow stages with strobe high");
  latch_hold_a: assert property (!stb_lvl || !ce |=>
    $stable(st_r.latches))
    else $error("latches changed with strobe low");

  // sinks
  drive_pattern_a: assert property (ce && oe_lvl |=>
    led_sink_outputs_oe == $past(st_r.latches))
    else $error("sinks do not show the latches");
  float_off_a: assert property (ce && !oe_lvl |=> led_sink_outputs_oe == '0)
    else $error("sink driven while disabled");
  sink_low_a: assert property (led_sink_outputs_oe != '0 |->
    led_sink_outputs_o == '0)
    else $error("sink drives high");
  zero_floats_a: assert property (ce |=>
    (led_sink_outputs_oe & ~$past(st_r.latches)) == '0)
    else $error("a stored zero sinks current");
  // a held pattern stays lit with no flicker
  sink_steady_a: assert property (ce && oe_lvl && !stb_lvl ##1 ce && oe_lvl && !stb_lvl |=>
    $stable(led_sink_outputs_oe))
    else $error("sinks changed with latches and enable held");

  // cascades
  rise_tap_a: assert property (ce && pop_take && pop_ev.is_rise |=>
    cascade_out_rise == $past(st_r.stages[`SSLD_RISE_TAP]))
    else $error("rise cascade missed stage six");
  rise_hold_a: assert property (ce && pop_take && !pop_ev.is_rise |=>
    $stable(cascade_out_rise))
    else $error("rise cascade moved on a falling edge");
  fall_tap_a: assert property (ce && pop_take && !pop_ev.is_rise |=>
    cascade_out_fall == $past(st_r.stages[`SSLD_FALL_TAP]))
    else $error("fall cascade missed stage seven");
  fall_hold_a: assert property (ce && pop_take && pop_ev.is_rise |=>
    $stable(cascade_out_fall))
    else $error("fall cascade moved on a rising edge");
  casc_idle_a: assert property (ce && !pop_take |=>
    $stable(cascade_out_rise) && $stable(cascade_out_fall))
    else $error("cascade moved with no shift clock edge");

  // clock enable
  freeze_a: assert property (!ce |=> $stable(st_r))
    else $error("state moved with clock enable low");
  queue_freeze_a: assert property (!ce |=>
    $stable(edge_room) && $stable(pop_valid))
    else $error("edge queue moved with clock enable low");

  // scenarios worth seeing at least once
  shift_seen_c: cover property (ce && pop_take && pop_ev.is_rise);
  latch_kept_c: cover property (ce && !stb_lvl && pop_take && pop_ev.is_rise);
  strobe_drive_c: cover property (ce && stb_lvl ##1 ce && oe_lvl && st_r.latches != '0);
  queue_full_c: cover property (!edge_room);
  fall_out_c: cover property (ce && pop_take && !pop_ev.is_rise ##1 cascade_out_fall);
endmodule : ssld_core

//--- hw/ssld_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, async high reset, clock enable freezing all state
`timescale 1ns/10ps
`include "ssld_regs.svh"
module ssld_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = `SSLD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ssld_fifo_state_t;

  ssld_fifo_state_t st_r;
  ssld_fifo_state_t st_nxt;
  logic full;
  logic empty;

  // ------------------------------------------------------------
  // flags: pointers carry one extra wrap bit
  // ------------------------------------------------------------
  assign empty = (st_r.wr == st_r.rd);
  assign full = (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]) && (st_r.wr[AW] != st_r.rd[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = st_r.mem[st_r.rd[AW-1:0]];

  // next state: push and pop may share a cycle
  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.mem[st_r.wr[AW-1:0]] = in_data;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  // storage is cleared too, so reads after reset are defined
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule : ssld_fifo

//--- hw/ssld_pkg.sv
// types shared by the shift-store led sink driver files
// assumes ssld_regs.svh is on the include path
`include "ssld_regs.svh"
package ssld_pkg;
  // ------------------------------------------------------------
  // one shift clock edge, queued between sampler and core
  // ------------------------------------------------------------
  typedef struct packed {
    logic is_rise;
    logic data;
  } ssld_event_t;

  // ------------------------------------------------------------
  // all state of the core
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`SSLD_PINS-1:0] pin_s1;
    logic [`SSLD_PINS-1:0] pin_s2;
    logic clk_s3;
    logic [`SSLD_STAGES-1:0] stages;
    logic [`SSLD_STAGES-1:0] latches;
    logic casc_rise;
    logic casc_fall;
    logic [`SSLD_STAGES-1:0] sink_oe;
  } ssld_state_t;
endpackage : ssld_pkg

//--- hw/ssld_regs.svh
// constants for the shift-store led sink driver: counts, taps, reset values
// assumes it is included by bare name from files under hw/
// How it works
// - eight stages advance on shift clock rise
// - serial bit enters first, others move up
// - latches follow stages while strobe high
// - enable high shows latches on sinks
// - enable low floats all eight sinks
// - stored one pulls low, zero floats
// - rise cascade takes stage six on rise
// - fall cascade takes stage seven on fall
`ifndef SSLD_REGS_SVH
`define SSLD_REGS_SVH

// ------------------------------------------------------------
// structure
// ------------------------------------------------------------
`define SSLD_STAGES 8
`define SSLD_FIFO_DEPTH 16
`define SSLD_RISE_TAP 6
`define SSLD_FALL_TAP 7

// ------------------------------------------------------------
// pin vector positions and reset values
// ------------------------------------------------------------
`define SSLD_PIN_CLK 0
`define SSLD_PIN_DATA 1
`define SSLD_PIN_STB 2
`define SSLD_PIN_OE 3
`define SSLD_PINS 4
`define SSLD_RST_BIT 1'b0
`define SSLD_RST_BYTE 8'h00
`define SSLD_RST_PINS 4'h0

`endif

//--- tb/ssld_host.sv
// controller model that drives the four device pins
// assumes clk is the system clock; pins move on its falling edge
`timescale 1ns/10ps
module ssld_host (
  input wire logic clk,
  output logic shift_clock,
  output logic serial_in,
  output logic latch_transfer,
  output logic output_enable
);
  // --------------------
  // pin drivers
  // --------------------
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    latch_transfer = 1'b0;
    output_enable = 1'b0;
  end

  // 8 clk per phase, well above the 3 the sampler needs
  task automatic shift_bit(input logic b);
    @(negedge clk) serial_in = b;
    repeat (3) @(negedge clk);
    shift_clock = 1'b1;
    repeat (8) @(negedge clk);
    shift_clock = 1'b0;
    repeat (8) @(negedge clk);
    serial_in = ~b; // stale data never looks valid
  endtask : shift_bit

  // strobe and enable levels, then time for them to land
  task automatic set_ctl(input logic stb, input logic en);
    @(negedge clk);
    latch_transfer = stb;
    output_enable = en;
    repeat (8) @(negedge clk);
  endtask : set_ctl
endmodule : ssld_host

//--- tb/tb_top.sv
// top bench: random and corner bytes through the driver
// assumes ssld_core and ssld_host are compiled before it
`timescale 1ns/10ps
module tb_top;
  logic clk, sys_rst, ce, queue_stall, edge_room;
  logic shift_clock, serial_in, latch_transfer, output_enable;
  logic cascade_out_rise, cascade_out_fall;
  logic [7:0] sink_o, sink_oe, exp_st, exp_lat, v;
  logic exp_rise, exp_fall;
  wire [7:0] led_pin;
  int bad_count, check_count, seed;
  // --------------------
  // design, partner, pin resolution
  // --------------------
  for (genvar g = 0; g < 8; g++) begin : g_pin
    assign led_pin[g] = sink_oe[g] ? sink_o[g] : 1'bz;
  end
  ssld_core #(.STAGES(8), .DEPTH(16)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .shift_clock(shift_clock), .serial_in(serial_in), .latch_transfer(latch_transfer),
    .output_enable(output_enable), .queue_stall(queue_stall), .edge_room(edge_room),
    .led_sink_outputs_o(sink_o), .led_sink_outputs_oe(sink_oe),
    .cascade_out_rise(cascade_out_rise), .cascade_out_fall(cascade_out_fall));
  ssld_host host (.clk(clk), .shift_clock(shift_clock), .serial_in(serial_in),
    .latch_transfer(latch_transfer), .output_enable(output_enable));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // stored one sinks low, all else floats
  function automatic logic [7:0] pins(input logic [7:0] lat, input logic en);
    for (int i = 0; i < 8; i++) pins[i] = (en && lat[i]) ? 1'b0 : 1'bz;
  endfunction : pins

  task automatic check_vec(input string name, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, e, s);
    end
  endtask : check_vec

  // shift a byte msb first while tracking stages and taps
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      exp_rise = exp_st[6];
      exp_st = {exp_st[6:0], b[i]};
      exp_fall = exp_st[7];
      host.shift_bit(b[i]);
    end
  endtask : send

  task automatic check_taps();
    check_vec("rise", {7'h00, exp_rise}, {7'h00, cascade_out_rise});
    check_vec("fall", {7'h00, exp_fall}, {7'h00, cascade_out_fall});
  endtask : check_taps

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    test_done();
  end
  // --------------------
  // main sequence
  // --------------------
  initial begin
    seed = 81;
    sys_rst = 1'b1;
    ce = 1'b1;
    queue_stall = 1'b0;
    {exp_st, exp_lat, exp_rise, exp_fall} = '0;
    repeat (6) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    check_vec("room", 8'h01, {7'h00, edge_room});
    host.set_ctl(1'b0, 1'b1);
    check_vec("idle", pins(8'h00, 1'b1), led_pin);
    for (int n = 0; n < 14; n++) begin
      v = (n < 4) ? {n[1], 6'h00, n[0]} ^ {8{n[1]}} : 8'($random(seed));
      send(v);
      check_taps();
      // enable still stands as the previous pass left it
      check_vec("hold", pins(exp_lat, ~n[0]), led_pin);
      host.set_ctl(1'b1, 1'b1);
      exp_lat = exp_st;
      check_vec("load", pins(exp_lat, 1'b1), led_pin);
      host.set_ctl(1'b0, n[0]);
      check_vec("enable", pins(exp_lat, n[0]), led_pin);
    end
    // strobe held high: latches follow every shift
    host.set_ctl(1'b1, 1'b1);
    send(8'hA5);
    check_vec("follow", pins(exp_st, 1'b1), led_pin);
    // stalled queue takes one byte of edges, then drains
    host.set_ctl(1'b0, 1'b1);
    exp_lat = exp_st;
    @(negedge clk) queue_stall = 1'b1;
    send(8'($random(seed)));
    check_vec("full", 8'h00, {7'h00, edge_room});
    @(negedge clk) queue_stall = 1'b0;
    repeat (30) @(negedge clk);
    check_taps();
    check_vec("hold2", pins(exp_lat, 1'b1), led_pin);
    host.set_ctl(1'b1, 1'b1);
    check_vec("drain", pins(exp_st, 1'b1), led_pin);
    // clock enable low: pin changes are not even sampled
    @(negedge clk) ce = 1'b0;
    host.set_ctl(1'b0, 1'b0);
    check_vec("freeze", pins(exp_st, 1'b1), led_pin);
    @(negedge clk) ce = 1'b1;
    host.set_ctl(1'b0, 1'b0);
    check_vec("thaw", pins(exp_st, 1'b0), led_pin);
    test_done();
  end
endmodule : tb_top
